//--- rtl/rail_ctl_cfg.svh
// Offsets, field positions, reset values and codes of the rail control registers.
// Assumes inclusion by the register block only; the package does not include it.
`ifndef RAIL_CTL_CFG_SVH
`define RAIL_CTL_CFG_SVH
`define OFF_RAIL_ENABLE   8'h01
`define OFF_POS_TRIM      8'h02
`define OFF_NEG_TRIM      8'h03
`define RST_RAIL_ENABLE   8'h1F
`define RST_POS_TRIM      8'h23
`define RST_NEG_TRIM_LOW  7'h23
`define BIT_NEG_LDO       0
`define BIT_GATE_LOW      1
`define BIT_POS_LDO       2
`define BIT_GATE_HIGH     3
`define FLD_HI_LSB        4
`define FLD_LO_LSB        0
`define BIT_BIAS_SRC      7
`define TRIM_NOMINAL      3'h2
`define TRIM_MAX_CODE     3'h4
`define LEVEL_DEFAULT     3'h3
`define LEVEL_MAX_CODE    3'h6
`define POS_MASK          8'h77
`define NEG_MASK          8'hF7
`endif

//--- rtl/rail_ctl_pkg.sv
// Types shared by the rail control register block.
// Assumes the constants header sits beside it.
package rail_ctl_pkg;
  // Register write strobe with address and data
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  // Per-rail gate from the external power pins
  typedef struct packed {
    logic gate_high;
    logic pos_ldo;
    logic gate_low;
    logic neg_ldo;
  } rail_set_t;

  // Analog settings handed to the regulators
  typedef struct packed {
    logic [2:0] gate_high_trim;
    logic [2:0] pos_source_offset;
    logic [2:0] gate_low_trim;
    logic [2:0] neg_source_level;
  } analog_set_t;
endpackage

//--- rtl/pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes one clock; the output is only valid two edges after the pin moves.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] level_q;
  logic [W-1:0] level_d;

  // First stage feeds only the second
  always_comb begin
    meta_d  = pin;
    level_d = meta_q;
  end

  // Both stages clear on reset
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q  <= '0;
      level_q <= '0;
    end else begin
      meta_q  <= meta_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule

//--- rtl/rail_ctl_regs.sv
// Rail enable and level registers with the source-rail interlock.
// Assumes a host-side serial engine delivers one-cycle write strobes and reads
// combinationally-decoded data registered here; power pins are asynchronous.
// How it works
// - Each rail enable bit switches its rail on at 1 and off at 0.
// - The positive source regulator never turns on unless the negative one is enabled.
// - Disabling the negative source regulator forces the positive one off too.
// - Each effective enable is its register bit ANDed with its power pin gate.
// - Gate-high trim maps 000..100 from +10 to -10 percent, 101..111 reserved.
// - Negative level runs -15.75 V to -14.25 V, and the positive rail follows it.
// - Backplane bias source picks the pin at 0 and the register value at 1.
// - The backplane bias source bit resets to 1 or 0 by device variant.
// - Gate-low trim maps 000..100 from -10 to +10 percent, 101..111 reserved.
`timescale 1ns/1ps
`include "rail_ctl_cfg.svh"
module rail_ctl_regs #(
  parameter bit BIAS_SRC_RESET = 1'b1
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire rail_ctl_pkg::reg_wr_t     wr_in,
  input  wire logic [7:0]                rd_addr,
  output logic      [7:0]                rd_data,
  input  wire rail_ctl_pkg::rail_set_t   power_pin_gates,
  input  wire logic                      backplane_bias_pin,
  output rail_ctl_pkg::rail_set_t        rail_on,
  output rail_ctl_pkg::analog_set_t      analog,
  output logic                           bias_from_pin,
  output logic                           backplane_bias_source
);
  import rail_ctl_pkg::*;

  // Stored register bytes and their next values
  logic [7:0]  enable_q;
  logic [7:0]  enable_d;
  logic [7:0]  pos_q;
  logic [7:0]  pos_d;
  logic [7:0]  neg_q;
  logic [7:0]  neg_d;

  // Output flops and their next values
  logic [7:0]  rd_q;
  logic [7:0]  rd_d;
  rail_set_t   on_q;
  rail_set_t   on_d;
  analog_set_t ana_q;
  analog_set_t ana_d;
  logic        bpin_q;
  logic        bpin_d;

  // Synchronised pins: gate_high, pos_ldo, gate_low, neg_ldo, then the bias pin
  logic [4:0]  pin_lvl;
  rail_set_t   pin_gate;

  // Trim codes above 100 are reserved; keep the prior value
  function automatic logic [2:0] keep_trim(input logic [2:0] nw, input logic [2:0] old);
    keep_trim = (nw > `TRIM_MAX_CODE) ? old : nw;
  endfunction

  // Level codes above 110 are reserved; keep the prior value
  function automatic logic [2:0] keep_level(input logic [2:0] nw, input logic [2:0] old);
    keep_level = (nw > `LEVEL_MAX_CODE) ? old : nw;
  endfunction

  // Upper three-bit field of an adjustment byte
  function automatic logic [2:0] hi_field(input logic [7:0] b);
    hi_field = b[`FLD_HI_LSB +: 3];
  endfunction

  // Lower three-bit field of an adjustment byte
  function automatic logic [2:0] lo_field(input logic [7:0] b);
    lo_field = b[`FLD_LO_LSB +: 3];
  endfunction

  // Only three offsets are mapped; anything else is ignored on write and reads zero
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `OFF_RAIL_ENABLE) || (a == `OFF_POS_TRIM) || (a == `OFF_NEG_TRIM);
  endfunction

  // Pins are asynchronous, so they pass two flops first.
  // Cost: a pin change reaches a rail three edges later, two of them spent here.
  pin_sync #(.W(5)) pin_sync_inst (
    .clk   (clk),
    .srst  (srst),
    .pin   ({power_pin_gates, backplane_bias_pin}),
    .level (pin_lvl)
  );

  // The bias pin level rides along in the synchroniser but gates nothing here;
  // the bias amplifier listens to the pin itself while bias_from_pin is high.
  assign pin_gate = pin_lvl[4:1];

  // Register writes; each field is judged on its own, so a reserved trim code
  // does not stop a good level code in the same byte from landing
  always_comb begin
    enable_d = enable_q;
    pos_d    = pos_q;
    neg_d    = neg_q;
    if (wr_in.wr && is_mapped(wr_in.addr)) begin
      case (wr_in.addr)
        `OFF_RAIL_ENABLE: begin
          // Whole byte is stored; only the low four bits reach a rail
          enable_d = wr_in.data;
        end
        `OFF_POS_TRIM: begin
          // Any legal offset is taken, but only 011 keeps the two source rails tracking;
          // holding it there is left to the host
          pos_d[`FLD_HI_LSB +: 3] = keep_trim(hi_field(wr_in.data), hi_field(pos_q));
          pos_d[`FLD_LO_LSB +: 3] = keep_level(lo_field(wr_in.data), lo_field(pos_q));
          pos_d                   = pos_d & `POS_MASK;
        end
        `OFF_NEG_TRIM: begin
          // Bias source bit is stored as written; bit 3 is masked off below
          neg_d[`BIT_BIAS_SRC]    = wr_in.data[`BIT_BIAS_SRC];
          neg_d[`FLD_HI_LSB +: 3] = keep_trim(hi_field(wr_in.data), hi_field(neg_q));
          neg_d[`FLD_LO_LSB +: 3] = keep_level(lo_field(wr_in.data), lo_field(neg_q));
          neg_d                   = neg_d & `NEG_MASK;
        end
        default: begin
          // Unreachable behind is_mapped; kept so the case is complete
          enable_d = enable_q;
        end
      endcase
    end
  end

  // Effective rail enables: each register bit ANDed with its synchronised pin gate.
  // The positive source looks at the negative one's registered state, so it can only
  // come on the cycle after the negative one is on. It also looks at the negative
  // one's next state, so both fall on the same edge and the positive rail never
  // stands alone, not even for one cycle.
  always_comb begin
    on_d.gate_high = enable_q[`BIT_GATE_HIGH] & pin_gate.gate_high;
    on_d.gate_low  = enable_q[`BIT_GATE_LOW] & pin_gate.gate_low;
    on_d.neg_ldo   = enable_q[`BIT_NEG_LDO] & pin_gate.neg_ldo;
    on_d.pos_ldo   = enable_q[`BIT_POS_LDO] & pin_gate.pos_ldo & on_q.neg_ldo & on_d.neg_ldo;
  end

  // Analog settings follow the stored bytes one edge later.
  // The positive offset is relative, so the positive rail follows a new
  // negative level inside the regulator without any logic here.
  always_comb begin
    ana_d.gate_high_trim    = hi_field(pos_q);
    ana_d.pos_source_offset = lo_field(pos_q);
    ana_d.gate_low_trim     = hi_field(neg_q);
    ana_d.neg_source_level  = lo_field(neg_q);
    // Taken from the next value so the flag never lags the source bit output
    bpin_d = ~neg_d[`BIT_BIAS_SRC];
  end

  // Read-back; unmapped addresses read zero.
  // Registered so rd_data is a flop: the host sees data one edge after the address.
  always_comb begin
    rd_d = 8'h00;
    if (is_mapped(rd_addr)) begin
      case (rd_addr)
        `OFF_RAIL_ENABLE: rd_d = enable_q;
        `OFF_POS_TRIM:    rd_d = pos_q & `POS_MASK;
        `OFF_NEG_TRIM:    rd_d = neg_q & `NEG_MASK;
        default:          rd_d = 8'h00;
      endcase
    end
  end

  // Register bytes return to their power-on values on reset;
  // the bias source bit's value depends on the device variant
  always_ff @(posedge clk) begin
    if (srst) begin
      enable_q <= `RST_RAIL_ENABLE;
      pos_q    <= `RST_POS_TRIM;
      neg_q    <= {BIAS_SRC_RESET, `RST_NEG_TRIM_LOW};
    end else begin
      enable_q <= enable_d;
      pos_q    <= pos_d;
      neg_q    <= neg_d;
    end
  end

  // Rails start off and only rise once reset has cleared;
  // the pins are also still settling in the synchroniser then
  // so an early rise would act on stale pin levels
  always_ff @(posedge clk) begin
    if (srst) begin
      on_q <= '0;
    end else begin
      on_q <= on_d;
    end
  end

  // Analog settings and bias selector; the selector resets to
  // the inverse of the variant's bias source bit
  always_ff @(posedge clk) begin
    if (srst) begin
      ana_q  <= '0;
      bpin_q <= ~BIAS_SRC_RESET;
    end else begin
      ana_q  <= ana_d;
      bpin_q <= bpin_d;
    end
  end

  // Read data
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  // Every output comes straight from a flop, so nothing combinational
  // reaches the analog side or the host
  assign rd_data               = rd_q;
  assign rail_on               = on_q;
  assign analog                = ana_q;
  assign bias_from_pin         = bpin_q;
  assign backplane_bias_source = neg_q[`BIT_BIAS_SRC];
endmodule

//--- bench/rail_ctl_regs_asserts.sv
// Checker for the rail control registers, bound to rail_ctl_regs.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module rail_ctl_regs_asserts (
  input wire logic                      clk,
  input wire logic                      srst,
  input wire rail_ctl_pkg::reg_wr_t     wr_in,
  input wire logic [7:0]                rd_addr,
  input wire logic [7:0]                rd_data,
  input wire rail_ctl_pkg::rail_set_t   power_pin_gates,
  input wire rail_ctl_pkg::rail_set_t   rail_on,
  input wire rail_ctl_pkg::analog_set_t analog,
  input wire logic                      bias_from_pin,
  input wire logic                      backplane_bias_source
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Interlock, gating and field limits
  a_pos_after_neg: assert property (rail_on.pos_ldo |-> $past(rail_on.neg_ldo))
    else $error("pos rail led neg");
  a_neg_drops_pos: assert property (!rail_on.neg_ldo |-> !rail_on.pos_ldo)
    else $error("pos rail on with neg off");
  a_pin_gates_on: assert property (rail_on.gate_high |-> $past(power_pin_gates.gate_high, 3))
    else $error("rail on with pin low");
  a_bit_turns_off: assert property (wr_in.wr && wr_in.addr == 8'h01 && !wr_in.data[1] |-> ##2 !rail_on.gate_low)
    else $error("rail stayed on");
  a_bias_select: assert property (bias_from_pin == !backplane_bias_source)
    else $error("bias source mismatch");
  a_unused_zero: assert property (rd_addr == 8'h02 |=> !rd_data[7] && !rd_data[3])
    else $error("unused bit set");
  a_high_trim: assert property (analog.gate_high_trim <= 3'h4)
    else $error("high trim reserved");
  a_low_trim: assert property (analog.gate_low_trim <= 3'h4)
    else $error("low trim reserved");
  c_all_on: cover property (rail_on == 4'hF);
  c_pin_bias: cover property (bias_from_pin);
  c_trim_max: cover property (analog.gate_high_trim == 3'h4);
endmodule

//--- bench/host_model.sv
// Host model: serial master issuing register writes and reads.
// Assumes the bench calls its tasks; it moves 1 ns after a rising edge.
`timescale 1ns/1ps
module host_model (
  input  wire logic             clk,
  input  wire logic [7:0]       rd_data,
  output rail_ctl_pkg::reg_wr_t wr_in = '0,
  output logic      [7:0]       rd_addr = 8'h00
);
  // Idle bus shows the inverse so stale data cannot pass for a write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 wr_in = {1'b1, a, d};
    @(posedge clk) #1 wr_in = {1'b0, ~a, ~d};
  endtask
  // Read data lands one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1 rd_addr = a;
    @(posedge clk) #1 d = rd_data;
  endtask
endmodule

//--- bench/rail_ctl_regs_test.sv
// Bench for the rail control registers: resets, interlock, pin gating, codes.
// Assumes the host model drives the register port; pins are driven here.
`timescale 1ns/1ps
module rail_ctl_regs_test;
  import rail_ctl_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, backplane_bias_pin = 1'b0;
  logic        bias_from_pin, backplane_bias_source;
  logic [7:0]  rd_addr, rd_data, v;
  rail_set_t   power_pin_gates = 4'hF, rail_on;
  reg_wr_t     wr_in;
  analog_set_t analog;
  int          n_mismatch = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  host_model host_model_inst (
    .clk     (clk),
    .rd_data (rd_data),
    .wr_in   (wr_in),
    .rd_addr (rd_addr)
  );
  rail_ctl_regs rail_ctl_regs_inst (
    .clk                   (clk),
    .srst                  (srst),
    .wr_in                 (wr_in),
    .rd_addr               (rd_addr),
    .rd_data               (rd_data),
    .power_pin_gates       (power_pin_gates),
    .backplane_bias_pin    (backplane_bias_pin),
    .rail_on               (rail_on),
    .analog                (analog),
    .bias_from_pin         (bias_from_pin),
    .backplane_bias_source (backplane_bias_source)
  );
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    host_model_inst.rd(a, v);
    chk(nm, {4'h0, v}, {4'h0, exp});
  endtask
  // Reset values, and an unmapped place reads zero
  task automatic t_reset;
    rd_chk("en", 8'h01, 8'h1F);
    rd_chk("pos", 8'h02, 8'h23);
    rd_chk("neg", 8'h03, 8'hA3);
    rd_chk("free", 8'h05, 8'h00);
    chk("src", {11'h0, backplane_bias_source}, 12'h001);
    chk("on", {8'h0, rail_on}, 12'h00F);
  endtask
  // Positive source never leads, and drops with the negative one
  task automatic t_interlock;
    host_model_inst.wr(8'h01, 8'h1C);
    @(posedge clk) #1;
    chk("lock", {8'h0, rail_on}, 12'h008);
    host_model_inst.wr(8'h01, 8'h1F);
    @(posedge clk) #1;
    chk("lead", {8'h0, rail_on}, 12'h00B);
    @(posedge clk) #1;
    chk("all", {8'h0, rail_on}, 12'h00F);
    host_model_inst.wr(8'h01, 8'h1E);
    @(posedge clk) #1;
    chk("drop", {8'h0, rail_on}, 12'h00A);
  endtask
  // Pin gate low holds a rail off; clearing a bit turns it off
  task automatic t_pins;
    host_model_inst.wr(8'h01, 8'h1F);
    power_pin_gates = 4'h7;
    repeat (4) @(posedge clk);
    #1;
    chk("pin", {8'h0, rail_on}, 12'h007);
    power_pin_gates = 4'hF;
    host_model_inst.wr(8'h01, 8'h1D);
    repeat (4) @(posedge clk);
    #1;
    chk("gl", {8'h0, rail_on}, 12'h00D);
  endtask
  // Reserved codes keep the old field; bias source follows bit 7
  task automatic t_codes;
    host_model_inst.wr(8'h02, 8'hF7);
    rd_chk("rsv", 8'h02, 8'h23);
    host_model_inst.wr(8'h02, 8'h43);
    host_model_inst.wr(8'h03, 8'h46);
    rd_chk("lvl", 8'h03, 8'h46);
    chk("ana", analog, 12'h8E6);
    chk("bp", {11'h0, bias_from_pin}, 12'h001);
    chk("src1", {11'h0, backplane_bias_source}, 12'h000);
    host_model_inst.wr(8'h03, 8'hFF);
    rd_chk("keep", 8'h03, 8'hC6);
    chk("bs", {11'h0, bias_from_pin}, 12'h000);
    chk("src2", {11'h0, backplane_bias_source}, 12'h001);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    t_reset;
    t_interlock;
    t_pins;
    t_codes;
    summarize;
  end
  // Hang guard
  initial begin
    #50000 n_mismatch++;
    summarize;
  end
endmodule
bind rail_ctl_regs rail_ctl_regs_asserts rail_ctl_regs_asserts_inst (
  .clk                   (clk),
  .srst                  (srst),
  .wr_in                 (wr_in),
  .rd_addr               (rd_addr),
  .rd_data               (rd_data),
  .power_pin_gates       (power_pin_gates),
  .rail_on               (rail_on),
  .analog                (analog),
  .bias_from_pin         (bias_from_pin),
  .backplane_bias_source (backplane_bias_source)
);
